// [pkg/window_base_pkg.sv]
// constants for the header-type byte and graphics window base register
package window_base_pkg;

  // =====================================================================
  // register offsets
  localparam logic [7:0]  HDR_TYPE_OFFSET      = 8'h0E;
  localparam logic [7:0]  WINDOW_BASE_OFFSET   = 8'h10;
  localparam logic [7:0]  BASE_DWORD_OFFSET    = 8'h10;
  localparam logic [7:0]  HDR_DWORD_OFFSET     = 8'h0C;

  // =====================================================================
  // header-type values
  localparam logic [7:0]  HDR_MULTI_FUNC       = 8'h80;
  localparam logic [7:0]  HDR_SINGLE_FUNC      = 8'h00;
  localparam int          HDR_BYTE_LANE        = 2;

  // =====================================================================
  // window base field layout
  localparam int          UPPER_MSB            = 31;
  localparam int          UPPER_LSB            = 28;
  localparam int          SIZE_BIT_HI          = 27;
  localparam int          SIZE_BIT_LO          = 26;
  localparam int          PREFETCH_BIT         = 3;
  localparam logic [3:0]  UPPER_RESET          = 4'h0;
  localparam logic [31:0] WINDOW_BASE_RESET    = 32'h00000008;

  // size select bits that open base bits 27 and 26
  localparam int          SEL_BIT_HI           = 5;
  localparam int          SEL_BIT_LO           = 4;

  // =====================================================================
  // configuration access commands
  typedef enum logic [1:0] {
    CFG_IDLE  = 2'h0,
    CFG_READ  = 2'h1,
    CFG_WRITE = 2'h2
  } cfg_cmd_t;

endpackage

// [hdl/byte_merge.sv]
// byte-enable merge of write data into a stored 32-bit word
`timescale 1ns/1ps
module byte_merge (
  input  wire logic [31:0] old_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  be_in,
  output logic      [31:0] merged_out
);

  // =====================================================================
  // one lane per byte enable
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign merged_out[g*8 +: 8] = be_in[g] ? wdata_in[g*8 +: 8]
                                             : old_in[g*8 +: 8];
    end
  endgenerate

endmodule

// [hdl/host_bridge_header_aperture_base.sv]
// header-type byte and graphics window base register of the host bridge
//
// Behaviour
// RULE1 - header reads 80 when other functions enabled
// RULE2 - header reads 00 when only function 0
// RULE3 - header writes ignored, no storage
// RULE4 - base bits 31:28 read/write, reset zero
// RULE5 - bits 27:26 writable per window size
// RULE6 - base bits 25:22 always read zero
// RULE7 - select bit 5 gates base bit 27
// RULE8 - select bits 5:4 gate 27:26 if capability intact
// RULE9 - base bits 21:4 zero, writes ignored
// RULE10 - base bit 3 reads constant one
// RULE11 - reads side-effect free, all bytes returned
// RULE12 - base bits 2:1 read zero
// RULE13 - base bit 0 reads zero
// RULE14 - window access blocked until enable set
// RULE15 - firmware programs base before generic software
// RULE16 - forced bits read zero despite old writes
`timescale 1ns/1ps
module host_bridge_header_aperture_base
  import window_base_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [1:0]  cfg_cmd_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  input  wire logic        other_funcs_en_in,
  input  wire logic [5:4]  window_size_select_in,
  input  wire logic        capability_intact_in,
  input  wire logic        window_unblock_in,
  input  wire logic [31:0] mem_addr_in,
  input  wire logic        mem_valid_in,
  output logic      [31:0] cfg_rdata_out,
  output logic             cfg_ack_out,
  output logic      [31:0] graphics_window_base_out,
  output logic             window_hit_out
);

  // =====================================================================
  // command decode
  wire cfg_rd_w  = (cfg_cmd_in == CFG_READ);
  wire cfg_wr_w  = (cfg_cmd_in == CFG_WRITE);
  wire base_sel_w = (cfg_addr_in == BASE_DWORD_OFFSET);
  wire hdr_sel_w  = (cfg_addr_in == HDR_DWORD_OFFSET);

  // =====================================================================
  // header byte is pure logic, no flop behind it
  // the enable pin is read live, so a function change shows at once
  wire [7:0] header_layout_type_w = other_funcs_en_in ?
                                    HDR_MULTI_FUNC :    // RULE1
                                    HDR_SINGLE_FUNC;    // RULE2

  // =====================================================================
  // writable mask: only 31:28 always, 27/26 per size select
  // without intact capability bits 27:26 stay forced to zero
  wire bit27_open_w = capability_intact_in &
                      window_size_select_in[SEL_BIT_HI];          // RULE7 RULE8
  wire bit26_open_w = bit27_open_w &
                      window_size_select_in[SEL_BIT_LO];          // RULE5 RULE8

  // stored upper bits only; everything else is built at read time
  logic [3:0] upper_base_field_r;
  logic [3:0] upper_base_field_nxt;
  logic [1:0] size_dependent_base_field_r;
  logic [1:0] size_dependent_base_field_nxt;

  wire [31:0] stored_w = {upper_base_field_r, size_dependent_base_field_r,
                          26'h0000000};
  wire [31:0] merged_w;

  byte_merge i_byte_merge (
    .old_in     (stored_w),
    .wdata_in   (cfg_wdata_in),
    .be_in      (cfg_be_in),
    .merged_out (merged_w)
  );

  wire base_wr_w = cfg_wr_w & base_sel_w;
  assign upper_base_field_nxt = base_wr_w ? merged_w[UPPER_MSB:UPPER_LSB]
                                          : upper_base_field_r;  // RULE4
  // a closed bit ignores writes, so reopening it cannot bring back
  // a value that software wrote while it behaved as hardwired zero
  wire bit27_wr_w = base_wr_w & bit27_open_w;                      // RULE7
  wire bit26_wr_w = base_wr_w & bit26_open_w;                      // RULE5
  assign size_dependent_base_field_nxt[1] = bit27_wr_w ?
      merged_w[SIZE_BIT_HI] : size_dependent_base_field_r[1];      // RULE7
  assign size_dependent_base_field_nxt[0] = bit26_wr_w ?
      merged_w[SIZE_BIT_LO] : size_dependent_base_field_r[0];      // RULE5

  // forced bits mask the stored value so a later size change reads clean
  wire [31:0] window_base_w = {
      upper_base_field_r,
      size_dependent_base_field_r[1] & bit27_open_w,             // RULE16
      size_dependent_base_field_r[0] & bit26_open_w,             // RULE16
      4'h0,                                                      // RULE6
      18'h00000,                                                 // RULE9
      1'b1,                                                      // RULE10
      2'h0,                                                      // RULE12
      1'b0};                                                     // RULE13

  // header dword returns the byte in lane 2; writes have no target
  // RULE3
  wire [31:0] hdr_dword_w = {8'h00, header_layout_type_w, 16'h0000};

  // reads return the whole dword regardless of byte enables
  wire [31:0] rdata_w = base_sel_w ? window_base_w :
                        hdr_sel_w  ? hdr_dword_w : 32'h00000000;   // RULE11

  // window decode: blocked until software opens it
  // a closed size bit is a don't-care in the address compare
  wire hit_w = mem_valid_in & window_unblock_in &                  // RULE14
               ((mem_addr_in[SIZE_BIT_HI] == window_base_w[SIZE_BIT_HI])
                | ~bit27_open_w) &
               ((mem_addr_in[SIZE_BIT_LO] == window_base_w[SIZE_BIT_LO])
                | ~bit26_open_w) &
               (mem_addr_in[31:28] == window_base_w[31:28]);

  // =====================================================================
  // registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      upper_base_field_r          <= UPPER_RESET;                 // RULE4
      size_dependent_base_field_r <= 2'h0;
      cfg_rdata_out               <= 32'h00000000;
      cfg_ack_out                 <= 1'b0;
      graphics_window_base_out    <= WINDOW_BASE_RESET;
      window_hit_out              <= 1'b0;
    end else begin
      upper_base_field_r          <= upper_base_field_nxt;
      size_dependent_base_field_r <= size_dependent_base_field_nxt;
      cfg_rdata_out               <= cfg_rd_w ? rdata_w : 32'h00000000;
      cfg_ack_out                 <= cfg_rd_w | cfg_wr_w;
      graphics_window_base_out    <= window_base_w;
      window_hit_out              <= hit_w;
    end
  end

  // =====================================================================
  // checks
  // all checks live in the one clock domain, so clock and reset are
  // given once here
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  AST_HDR_MULTI: assert property (                           // RULE1
    cfg_rd_w && hdr_sel_w && other_funcs_en_in |=>
      cfg_rdata_out[23:16] == HDR_MULTI_FUNC)
    else $error("header byte not 80");

  AST_HDR_SINGLE: assert property (                          // RULE2
    cfg_rd_w && hdr_sel_w && !other_funcs_en_in |=>
      cfg_rdata_out[23:16] == HDR_SINGLE_FUNC)
    else $error("header byte not 00");

  AST_HDR_NOSTATE: assert property (                         // RULE3
    cfg_wr_w && hdr_sel_w |=> $stable(upper_base_field_r) &&
      $stable(size_dependent_base_field_r))
    else $error("header write changed state");

  AST_UPPER_WRITE: assert property (                         // RULE4
    base_wr_w && cfg_be_in[3] |=>
      upper_base_field_r == $past(cfg_wdata_in[31:28]))
    else $error("upper base bits not written");

  AST_BIT26_CLOSED: assert property (                        // RULE5
    !bit26_open_w |-> window_base_w[SIZE_BIT_LO] == 1'b0)
    else $error("bit 26 set while closed");

  AST_BIT27_CLOSED: assert property (                        // RULE7
    !window_size_select_in[SEL_BIT_HI] |-> !window_base_w[SIZE_BIT_HI])
    else $error("bit 27 set while closed");

  sequence s_base_read;
    cfg_rd_w && base_sel_w;
  endsequence

  AST_LOW_CONST: assert property (                           // RULE9
    s_base_read |=> cfg_rdata_out[25:0] == 26'h0000008)
    else $error("low base bits not constant");

  AST_HIT_BLOCKED: assert property (                         // RULE14
    !window_unblock_in |=> !window_hit_out)
    else $error("window hit while blocked");

endmodule

// [sim/host_bridge_header_aperture_base_tb.sv]
// self-checking bench for the header byte and graphics window base register
`timescale 1ns/1ps
module host_bridge_header_aperture_base_tb;
  import window_base_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [1:0]  cmd = CFG_IDLE;
  logic [7:0]  addr = 8'h00;
  logic [3:0]  be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        other_en = 1'b1;
  logic [5:4]  sel = 2'h0;
  logic        cap_ok = 1'b1;
  logic        unblock = 1'b0;
  logic [31:0] maddr = 32'h0;
  logic        mvalid = 1'b0;
  logic [31:0] rdata, base_view;
  logic        ack, hit;
  int          err_count = 0;
  int          checks = 0;
  host_bridge_header_aperture_base i_host_bridge_header_aperture_base (
    .clk_in(clk_in), .reset_in(reset_in), .cfg_cmd_in(cmd),
    .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wdata),
    .other_funcs_en_in(other_en), .window_size_select_in(sel),
    .capability_intact_in(cap_ok), .window_unblock_in(unblock),
    .mem_addr_in(maddr), .mem_valid_in(mvalid), .cfg_rdata_out(rdata),
    .cfg_ack_out(ack), .graphics_window_base_out(base_view),
    .window_hit_out(hit));
  // =====================================================================
  // clock, 4 ns period
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // =====================================================================
  // one configuration access; answer is awaited under a bounded count
  task automatic access(input logic [1:0] c, input logic [7:0] a,
                        input logic [3:0] b, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    cmd <= c; addr <= a; be <= b; wdata <= d;
    @(posedge clk_in);
    cmd <= CFG_IDLE;
    // the answer stands for the cycle right after the taking edge
    for (n = 0; n < 4; n++) begin
      #1;
      if (ack === 1'b1) break;
      @(posedge clk_in);
    end
    if (n == 4) begin
      check(32'h1, 32'h0);
      end_of_test();
    end
  endtask
  // =====================================================================
  // header byte: value follows function enable, writes have no effect
  task automatic test_header();
    access(CFG_READ, HDR_DWORD_OFFSET, 4'h0, 32'h0);
    check(rdata[HDR_BYTE_LANE*8 +: 8], HDR_MULTI_FUNC);
    access(CFG_WRITE, HDR_DWORD_OFFSET, 4'hF, 32'h0000_0000);
    other_en <= 1'b0;
    access(CFG_READ, HDR_DWORD_OFFSET, 4'h0, 32'h0);
    check(rdata[HDR_BYTE_LANE*8 +: 8], HDR_SINGLE_FUNC);
    other_en <= 1'b1;
    access(CFG_WRITE, HDR_DWORD_OFFSET, 4'hF, 32'hFFFF_FFFF);
    access(CFG_READ, HDR_DWORD_OFFSET, 4'h0, 32'h0);
    check(rdata[HDR_BYTE_LANE*8 +: 8], HDR_MULTI_FUNC);
    access(CFG_READ, 8'h20, 4'h0, 32'h0);
    check(rdata, 32'h0);
    $display("test_header done");
  endtask
  // =====================================================================
  // all ones written under every size select; forced bits read zero
  task automatic test_sizes();
    logic [31:0] exp [4];
    exp[0] = 32'hF000_0008; exp[1] = 32'hF000_0008;
    exp[2] = 32'hF800_0008; exp[3] = 32'hFC00_0008;
    for (int s = 0; s < 4; s++) begin
      sel <= s[1:0];
      access(CFG_WRITE, WINDOW_BASE_OFFSET, 4'hF, 32'hFFFF_FFFF);
      access(CFG_READ, WINDOW_BASE_OFFSET, 4'h0, 32'h0);
      check(rdata, exp[s]);
      check(base_view, exp[s]);
      if (s == 1) begin
        // writes made while 27:26 were closed must not reappear
        sel <= 2'h3;
        access(CFG_READ, WINDOW_BASE_OFFSET, 4'h0, 32'h0);
        check(rdata, 32'hF000_0008);
      end
    end
    // stored bit 26 is left set, then the select closes it
    sel <= 2'h2;
    access(CFG_READ, WINDOW_BASE_OFFSET, 4'h0, 32'h0);
    check(rdata, 32'hF800_0008);
    sel <= 2'h3;
    cap_ok <= 1'b0;
    access(CFG_READ, WINDOW_BASE_OFFSET, 4'h0, 32'h0);
    check(rdata, 32'hF000_0008);
    cap_ok <= 1'b1;
    // partial write replaces only the top byte; read ignores enables
    access(CFG_WRITE, WINDOW_BASE_OFFSET, 4'h8, 32'h5000_0000);
    access(CFG_READ, WINDOW_BASE_OFFSET, 4'h1, 32'h0);
    check(rdata, 32'h5000_0008);
    $display("test_sizes done");
  endtask
  // =====================================================================
  // memory decode stays blocked until the unblock bit is set
  task automatic mem_cycle(input logic [31:0] a, input logic exp);
    @(posedge clk_in);
    maddr <= a; mvalid <= 1'b1;
    @(posedge clk_in);
    mvalid <= 1'b0;
    #1;
    check({31'h0, hit}, {31'h0, exp});
  endtask
  task automatic test_window();
    // base is programmed before the window is opened to users
    access(CFG_WRITE, WINDOW_BASE_OFFSET, 4'hF, 32'hC400_0000);
    mem_cycle(32'hC412_3456, 1'b0);
    unblock <= 1'b1;
    mem_cycle(32'hC7FF_FFFC, 1'b1);
    mem_cycle(32'hC800_0000, 1'b0);
    $display("test_window done");
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    #1;
    check(base_view, WINDOW_BASE_RESET);
    test_header();
    test_sizes();
    test_window();
    end_of_test();
  end
endmodule
